// file: core/etdp_edge_count.sv
// etdp_edge_count: synchronised edge detector and 26-bit totalizer
// assumes pulse_in is asynchronous to pclk; clear inputs come from pclk logic
`timescale 1ns/1ps
module etdp_edge_count (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                pulse_in,
  input  wire logic                                fall_edge,
  input  wire logic                                zero_req,
  output logic [etdp_pkg::COUNT_WIDTH-1:0]         count
);
  logic [2:0] sync_reg;
  logic       agreed_reg;
  logic [etdp_pkg::COUNT_WIDTH-1:0] count_reg;
  logic [etdp_pkg::COUNT_WIDTH-1:0] count_next;
  wire        stable_level;
  wire        changed;
  wire        qualifies;

  // first stage feeds only the second; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg   <= 3'h0;
      agreed_reg <= 1'b0;
    end else begin
      sync_reg   <= {sync_reg[1:0], pulse_in}; // RULE11
      agreed_reg <= stable_level;
    end
  end

  assign stable_level = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : agreed_reg;
  assign changed      = stable_level != agreed_reg;
  assign qualifies    = changed && (stable_level != fall_edge); // RULE1

  // max wraps to zero naturally at 26 bits; clear beats a coincident edge
  assign count_next = zero_req  ? etdp_pkg::COUNT_RESET :                  // RULE12
                      qualifies ? count_reg + 26'h0000001 : count_reg;    // RULE5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) count_reg <= etdp_pkg::COUNT_RESET;
    else          count_reg <= count_next;
  end

  assign count = count_reg;

  a_wrap_to_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (count_reg == etdp_pkg::COUNT_MAX && qualifies && !zero_req) |=> count_reg == 26'h0)
    else $error("count did not wrap to zero");
  a_edge_counts_one: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (qualifies && !zero_req) |=> count_reg == $past(count_reg) + 26'h0000001)
    else $error("edge did not add exactly one");
  a_clear_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    zero_req |=> count_reg == 26'h0)
    else $error("zero request lost to an edge");
endmodule : etdp_edge_count

// file: core/etdp_pkg.sv
// etdp_pkg: shared constants and types of the edge totalizer and output port block
// assumes an apb slave at 10 mhz; no other file defines these values
package etdp_pkg;
  localparam int unsigned COUNT_WIDTH = 26;
  localparam int unsigned PORT_WIDTH  = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_COUNT     = 8'h04;
  localparam logic [7:0] OFF_CLEAR     = 8'h08;
  localparam logic [7:0] OFF_PORT1     = 8'h0c;
  localparam logic [7:0] OFF_PORT2     = 8'h10;
  localparam logic [7:0] OFF_WORD      = 8'h14;
  localparam logic [7:0] OFF_DIR       = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1c;

  // control, clear and status register fields
  localparam int unsigned CTRL_FALL_BIT = 0;
  localparam int unsigned CTRL_RTZ_BIT  = 1;
  localparam int unsigned CTRL_IN1_BIT  = 2;
  localparam int unsigned CTRL_IN2_BIT  = 3;
  localparam int unsigned CTRL_OE1_BIT  = 4;
  localparam int unsigned CTRL_OE2_BIT  = 5;
  localparam int unsigned CLEAR_BIT     = 0;
  localparam int unsigned STAT_REFUSE_BIT = 0;

  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [25:0] COUNT_RESET  = 26'h0000000;
  localparam logic [25:0] COUNT_MAX    = 26'h3ffffff;
  localparam logic [7:0]  PORT_RESET   = 8'h00;

  typedef struct packed {
    logic       fall_edge;
    logic       read_then_zero;
    logic [1:0] scan_input;
    logic [1:0] out_enable;
  } etdp_ctrl_type;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } etdp_word_type;
endpackage : etdp_pkg

// file: core/etdp_top.sv
// etdp_top: apb slave with edge totalizer and two 8-bit output ports
// assumes an apb master at 10 mhz; pulse_in comes from an outside pin
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// How it works
// RULE1 - count rising edges by default, falling edges when falling slope is chosen
// RULE2 - an immediate clear write zeroes the count at once
// RULE3 - in read-then-zero mode a count read returns the value then zeroes it
// RULE4 - that zeroing ignores any scan state
// RULE5 - count is 26 bits and wraps to zero after 67,108,863
// RULE6 - byte writes per port; word write at port one sets both at once; the code takes the word write at OFF_WORD, not at port one
// RULE7 - output enable is refused for a port marked as scanned input
// RULE8 - port readback returns the last value written
// RULE9 - direction query gives 0 for input and 1 for output
// RULE10 - after reset reads leave the count unchanged
// RULE11 - input is synchronised before edge detection, one increment per edge
// RULE12 - a clear coinciding with a counted edge leaves the count zero
module etdp_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pulse_in,
  output logic [15:0]      port_out,
  output logic [1:0]       port_oe
);
  etdp_pkg::etdp_ctrl_type ctrl_reg;
  etdp_pkg::etdp_ctrl_type ctrl_next;
  etdp_pkg::etdp_word_type port_reg;
  etdp_pkg::etdp_word_type port_next;
  logic                    refused_reg;
  logic                    refused_next;
  logic [31:0]             prdata_reg;
  logic [31:0]             rdata_next;
  logic [etdp_pkg::COUNT_WIDTH-1:0] count;

  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire hit_ctrl = paddr == etdp_pkg::OFF_CTRL;
  wire hit_cnt  = paddr == etdp_pkg::OFF_COUNT;
  wire hit_clr  = paddr == etdp_pkg::OFF_CLEAR;
  wire hit_p1   = paddr == etdp_pkg::OFF_PORT1;
  wire hit_p2   = paddr == etdp_pkg::OFF_PORT2;
  wire hit_word = paddr == etdp_pkg::OFF_WORD;
  wire hit_dir  = paddr == etdp_pkg::OFF_DIR;
  wire hit_stat = paddr == etdp_pkg::OFF_STATUS;
  wire mapped   = hit_ctrl | hit_cnt | hit_clr | hit_p1 | hit_p2 | hit_word | hit_dir | hit_stat;

  wire clear_now      = wr && hit_clr && pwdata[etdp_pkg::CLEAR_BIT];       // RULE2
  wire rtz_read       = rd && hit_cnt && ctrl_reg.read_then_zero;           // RULE3 RULE4 RULE10
  wire zero_req       = clear_now || rtz_read;

  // requested output enables are masked by the scanned-input marks
  wire [1:0] want_in  = pwdata[etdp_pkg::CTRL_IN2_BIT:etdp_pkg::CTRL_IN1_BIT];
  wire [1:0] want_oe  = pwdata[etdp_pkg::CTRL_OE2_BIT:etdp_pkg::CTRL_OE1_BIT];
  wire [1:0] grant_oe = want_oe & ~want_in;                                 // RULE7
  wire       refuse   = wr && hit_ctrl && |(want_oe & want_in);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr && hit_ctrl) begin
      ctrl_next.fall_edge      = pwdata[etdp_pkg::CTRL_FALL_BIT];           // RULE1
      ctrl_next.read_then_zero = pwdata[etdp_pkg::CTRL_RTZ_BIT];
      ctrl_next.scan_input     = want_in;
      ctrl_next.out_enable     = grant_oe;                                  // RULE7
    end
  end

  // a word write lands both bytes in the same edge so the pins never show a half update
  always_comb begin
    port_next = port_reg;
    if (wr && hit_p1) port_next.lower = pwdata[7:0];
    if (wr && hit_p2) port_next.upper = pwdata[7:0];
    if (wr && hit_word) port_next = pwdata[15:0];                           // RULE6
  end

  assign refused_next = refuse ? 1'b1 :
                        (wr && hit_stat && pwdata[etdp_pkg::STAT_REFUSE_BIT]) ? 1'b0 :
                        refused_reg;

  always_comb begin
    rdata_next = 32'h00000000;
    if (hit_ctrl) rdata_next = {26'h0, ctrl_reg.out_enable, ctrl_reg.scan_input,
                                ctrl_reg.read_then_zero, ctrl_reg.fall_edge};
    if (hit_cnt)  rdata_next = {6'h00, count};                              // RULE3
    if (hit_p1)   rdata_next = {24'h000000, port_reg.lower};                // RULE8
    if (hit_p2)   rdata_next = {24'h000000, port_reg.upper};                // RULE8
    if (hit_word) rdata_next = {16'h0000, port_reg};                        // RULE8
    if (hit_dir)  rdata_next = {30'h0, ctrl_reg.out_enable};                // RULE9
    if (hit_stat) rdata_next = {31'h0, refused_reg};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= etdp_pkg::CTRL_RESET;                                  // RULE10
      port_reg    <= {etdp_pkg::PORT_RESET, etdp_pkg::PORT_RESET};
      refused_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      ctrl_reg    <= ctrl_next;
      port_reg    <= port_next;
      refused_reg <= refused_next;
      if (psel && !penable && !pwrite) prdata_reg <= rdata_next;
    end
  end

  etdp_edge_count u_count (
    .pclk      (pclk),
    .presetn   (presetn),
    .pulse_in  (pulse_in),
    .fall_edge (ctrl_reg.fall_edge),
    .zero_req  (zero_req),
    .count     (count)
  );

  // read data is latched in setup so a read-then-zero returns the pre-zero count
  assign prdata   = prdata_reg;
  assign pready   = 1'b1;
  assign pslverr  = access && !mapped;
  assign port_out = port_reg;
  assign port_oe  = ctrl_reg.out_enable;

  sequence s_word_write;
    wr && hit_word;
  endsequence

  a_word_both_bytes: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    s_word_write |=> port_out == $past(pwdata[15:0]))
    else $error("word write did not update both ports");
  a_no_out_on_scan: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (port_oe & ctrl_reg.scan_input) == 2'b00)
    else $error("scanned input port driven as output");
  a_clear_zeroes: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    clear_now |=> count == 26'h0)
    else $error("immediate clear did not zero count");
  a_rtz_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    rtz_read |-> (prdata == {6'h00, $past(count)}) ##1 count == 26'h0)
    else $error("read-then-zero failed");
  a_plain_read_keeps: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (rd && hit_cnt && !ctrl_reg.read_then_zero && !clear_now) |=> count == $past(count) ||
    count == $past(count) + 26'h0000001)
    else $error("plain read disturbed count");
  a_byte_readback: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (rd && hit_p1) |-> prdata[7:0] == $past(port_out[7:0]))
    else $error("port readback mismatch");
  a_dir_query: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (rd && hit_dir) |-> prdata[1:0] == port_oe)
    else $error("direction query mismatch");
  a_slope_falls: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (wr && hit_ctrl) |=> ctrl_reg.fall_edge == $past(pwdata[etdp_pkg::CTRL_FALL_BIT]))
    else $error("slope selection not stored");

  // read data is taken at the setup edge, so read checks look one cycle back, except a_dir_query which compares port_oe directly
  // a write lands only in its access cycle, so ports, modes and the refusal flag hold between two accesses
  sequence s_ctrl_write;
    wr && hit_ctrl;
  endsequence

  sequence s_refused_write;
    wr && hit_ctrl && |(want_oe & want_in);
  endsequence

  sequence s_status_clear;
    wr && hit_stat && pwdata[etdp_pkg::STAT_REFUSE_BIT];
  endsequence

  sequence s_count_read;
    rd && hit_cnt;
  endsequence

  sequence s_port1_write;
    wr && hit_p1;
  endsequence

  sequence s_port2_write;
    wr && hit_p2;
  endsequence

  sequence s_unmapped_access;
    access && !mapped;
  endsequence

  a_refuse_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    s_refused_write
    |=> refused_reg)
    else $error("refused output request not flagged");

  a_refused_oe_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    s_refused_write
    |=> (port_oe & $past(want_in)) == 2'b00)
    else $error("refused port became an output");

  a_oe_granted: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    s_ctrl_write
    |=> port_oe == ($past(want_oe) & ~$past(want_in)))
    else $error("free port output request not granted");

  a_status_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    s_status_clear
    |=> !refused_reg)
    else $error("refusal flag not cleared");

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    !(wr && (hit_ctrl || hit_stat))
    |=> refused_reg == $past(refused_reg))
    else $error("refusal flag changed without cause");

  a_port1_byte: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    s_port1_write
    |=> port_out[7:0] == $past(pwdata[7:0]) && port_out[15:8] == $past(port_out[15:8]))
    else $error("port one byte write wrong");

  a_port2_byte: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    s_port2_write
    |=> port_out[15:8] == $past(pwdata[7:0]) && port_out[7:0] == $past(port_out[7:0]))
    else $error("port two byte write wrong");

  a_ports_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    !(wr && (hit_p1 || hit_p2 || hit_word))
    |=> $stable(port_out))
    else $error("output ports moved without a write");

  a_oe_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    !(wr && hit_ctrl)
    |=> $stable(port_oe))
    else $error("port direction moved without a write");

  a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    !(wr && hit_ctrl)
    |=> $stable(ctrl_reg))
    else $error("mode changed without a write");

  a_port2_readback: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (rd && hit_p2)
    |-> prdata[7:0] == $past(port_out[15:8]))
    else $error("port two readback mismatch");

  a_word_readback: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (rd && hit_word)
    |-> prdata[15:0] == $past(port_out))
    else $error("word readback mismatch");

  a_word_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (rd && hit_word)
    |-> prdata[31:16] == 16'h0000)
    else $error("word readback upper half not zero");

  a_count_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    s_count_read
    |-> prdata == {6'h00, $past(count)})
    else $error("count read returned wrong value");

  a_rtz_scan_free: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (rd && hit_cnt && ctrl_reg.read_then_zero && |ctrl_reg.scan_input)
    |=> count == 26'h0)
    else $error("zeroing held back by scan marks");

  a_plain_no_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (rd && hit_cnt && !ctrl_reg.read_then_zero)
    |-> !zero_req)
    else $error("plain read asked for zeroing");

  a_ctrl_readback: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (rd && hit_ctrl)
    |-> prdata[etdp_pkg::CTRL_FALL_BIT] == $past(ctrl_reg.fall_edge) &&
        prdata[etdp_pkg::CTRL_RTZ_BIT] == $past(ctrl_reg.read_then_zero))
    else $error("control readback mismatch");

  a_prdata_holds: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    !(psel && !penable && !pwrite)
    |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  a_unmapped_inert: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    s_unmapped_access
    |=> $stable(port_out) && $stable(port_oe))
    else $error("unmapped access changed the ports");

  a_status_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (rd && hit_stat)
    |-> prdata == {31'h0, $past(refused_reg)})
    else $error("status readback mismatch");

  a_dir_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (rd && hit_dir)
    |-> prdata[31:2] == 30'h0)
    else $error("direction query upper bits not zero");

  a_scan_stored: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    s_ctrl_write
    |=> ctrl_reg.scan_input == $past(want_in))
    else $error("scanned input marks not stored");

  a_rtz_stored: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    s_ctrl_write
    |=> ctrl_reg.read_then_zero == $past(pwdata[etdp_pkg::CTRL_RTZ_BIT]))
    else $error("zeroing mode not stored");
endmodule : etdp_top

// file: sim/etdp_pulse_src.sv
// etdp_pulse_src: outside pulse source that feeds the totalizer input
// assumes start is held for one clock and pulses stay idle low between bursts
`timescale 1ns/1ps
module etdp_pulse_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [7:0] npulse,
  input  wire logic [3:0] hper,
  output logic            pulse_out,
  output logic            busy
);
  logic [8:0] left;
  logic [3:0] tick;
  // half period is hper+1 cycles, so for any hper above zero edges come no closer than the synchroniser needs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_out <= 1'b0;
      busy      <= 1'b0;
      left      <= 9'h000;
      tick      <= 4'h0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      left <= {npulse, 1'b0};
      tick <= hper;
    end else if (busy) begin
      if (tick != 4'h0) tick <= tick - 4'h1;
      else if (left == 9'h000) busy <= 1'b0;
      else begin
        pulse_out <= ~pulse_out;
        left      <= left - 9'h001;
        tick      <= hper;
      end
    end
  end
endmodule : etdp_pulse_src

// file: sim/etdp_top_tb.sv
// etdp_top_tb: self-checking bench with apb master and reference counter model
// assumes etdp_top answers with zero wait states and a pulse source on pulse_in
`timescale 1ns/1ps
module etdp_top_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start = 0;
  logic [7:0]  paddr = 0, npulse = 0;
  logic [3:0]  hper = 3;
  logic [31:0] pwdata = 0, prdata, rd, w;
  logic        pready, pslverr, pulse_in, busy, se;
  logic [15:0] port_out;
  logic [1:0]  port_oe;
  int          fail_count = 0, num_checks = 0, cyc = 0, cnt = 0;
  always #50 pclk = ~pclk;
  etdp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_in(pulse_in), .port_out(port_out), .port_oe(port_oe));
  etdp_pulse_src src (.pclk(pclk), .presetn(presetn), .start(start), .npulse(npulse),
    .hper(hper), .pulse_out(pulse_in), .busy(busy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulses();
    int k;
    k = 1 + $urandom % 20;
    @(posedge pclk);
    npulse <= k[7:0];
    hper   <= 4'(3 + $urandom % 4);
    start  <= 1'b1;
    @(posedge pclk);
    start  <= 1'b0;
    do @(posedge pclk); while (busy);
    repeat (6) @(posedge pclk);
    cnt = (cnt + k) % (1 << 26);
  endtask : pulses
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // generous ceiling: all tests together need fewer than 1500 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(84));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, etdp_pkg::OFF_CTRL, 0);
    chk(rd, 0);
    apb(0, etdp_pkg::OFF_DIR, 0);
    chk(rd, 0);
    pulses();
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    apb(1, etdp_pkg::OFF_CTRL, 32'h1);
    pulses();
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    $display("test edge count done");
    apb(1, etdp_pkg::OFF_CLEAR, 32'h1);
    cnt = 0;
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    apb(1, etdp_pkg::OFF_CTRL, 32'he);
    pulses();
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    cnt = 0;
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    $display("test clear and zeroing done");
    apb(1, etdp_pkg::OFF_CTRL, 32'h3);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cnt = 0;
    apb(0, etdp_pkg::OFF_CTRL, 0);
    chk(rd, 0);
    pulses();
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    apb(0, etdp_pkg::OFF_COUNT, 0);
    chk(rd, cnt);
    $display("test reset defaults done");
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      apb(1, etdp_pkg::OFF_PORT1, {24'h0, w[23:16]});
      apb(1, etdp_pkg::OFF_PORT2, {24'h0, w[31:24]});
      apb(0, etdp_pkg::OFF_PORT2, 0);
      chk(rd, {24'h0, w[31:24]});
      apb(1, etdp_pkg::OFF_WORD, {16'h0, w[15:0]});
      @(negedge pclk);
      chk({16'h0, port_out}, {16'h0, w[15:0]});
      apb(0, etdp_pkg::OFF_PORT1, 0);
      chk(rd, {24'h0, w[7:0]});
    end
    $display("test output ports done");
    apb(1, etdp_pkg::OFF_CTRL, 32'h30);
    apb(0, etdp_pkg::OFF_DIR, 0);
    chk(rd, 32'h3);
    apb(1, etdp_pkg::OFF_CTRL, 32'h14);
    @(negedge pclk);
    chk({30'h0, port_oe}, 32'h0);
    apb(0, etdp_pkg::OFF_STATUS, 0);
    chk(rd, 32'h1);
    apb(1, etdp_pkg::OFF_STATUS, 32'h1);
    apb(0, etdp_pkg::OFF_STATUS, 0);
    chk(rd, 32'h0);
    apb(0, 8'h20, 0);
    chk({31'h0, se}, 32'h1);
    chk(rd, 32'h0);
    $display("test direction and refusal done");
    finish_test();
  end
endmodule : etdp_top_tb
